//--- stm4_rs_pkg.sv
/*
 * Shared constants and types for the 622 Mbit/s regenerator-section block:
 * frame geometry, fixed overhead bytes, scrambler seed and timing figures.
 * Assumes one frame byte per clock of a 125 MHz clock and frames of 9 x 1080 bytes.
 */
package stm4_rs_pkg;

    localparam logic [3:0] LAST_ROW = 4'h8;
    localparam logic [3:0] OH_ROWS = 4'h3;
    localparam logic [3:0] PARITY_ROW = 4'h1;
    localparam logic [10:0] LAST_COL = 11'h437;
    localparam logic [10:0] SOH_COLS = 11'h024;
    localparam logic [10:0] A1_END_COL = 11'h00c;
    localparam logic [10:0] A2_END_COL = 11'h018;
    localparam logic [10:0] TRACE_COL = 11'h018;
    localparam logic [10:0] PARITY_COL = 11'h000;

    localparam logic [7:0] A1_BYTE = 8'hf6;
    localparam logic [7:0] A2_BYTE = 8'h28;
    // Alternating bits keep unscrambled spare bytes free of long runs.
    localparam logic [7:0] FILL_BYTE = 8'haa;
    localparam logic [7:0] ONES_BYTE = 8'hff;
    localparam logic [6:0] SCR_SEED = 7'h7f;
    localparam logic [7:0] SCR_FIRST_KEY = 8'hfe;

    localparam logic [1:0] TRACE_REPEAT = 2'h2;
    localparam logic [15:0] COUNT_MAX = 16'hffff;

    localparam int AIS_LIMIT_US = 250;
    localparam int CLK_PERIOD_NS = 8;
    localparam int AIS_LIMIT_CYCLES = AIS_LIMIT_US * 1000 / CLK_PERIOD_NS;

    typedef struct packed {
        logic [3:0] row;
        logic [10:0] col;
    } pos_type;

    typedef enum logic [2:0] {
        OH_A1,
        OH_A2,
        OH_TRACE,
        OH_SPARE_CLEAR,
        OH_PARITY,
        OH_SPARE_SCR,
        OH_PAYLOAD
    } byte_kind_type;

endpackage : stm4_rs_pkg

//--- stm4_payload_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides, used in the transmit payload path.
 * Assumes DEPTH is a power of two so that the pointers wrap on their own.
 */
`timescale 1ns/1ps
module stm4_payload_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic [AW:0] count_r, count_nxt;
    logic push, pop;

    assign in_ready = (count_r != FULL_COUNT);
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];

    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_ptr_nxt = push ? wr_ptr_r + AW'(1) : wr_ptr_r;
        rd_ptr_nxt = pop ? rd_ptr_r + AW'(1) : rd_ptr_r;
        count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
        end
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

endmodule : stm4_payload_fifo

//--- stm4_regen_section_termination.sv
/*
 * Regenerator-section termination for the 622 Mbit/s frame: transmit framer with
 * payload multiplexer and scrambler, receive descrambler with parity check, trace
 * handling, all-ones insertion and one-second performance counts.
 * Assumes byte-wide line data, one byte per clock, and frame-start strobes that mark
 * the first byte of each frame on each direction.
 */
//
// Summary of operation
// [R01] Transmit puts twelve first then twelve second alignment bytes at frame start.
// [R02] Transmit writes the configured trace identifier into the trace byte each frame.
// [R03] Transmit parity byte is even BIP-8 over the previous scrambled frame.
// [R04] Scrambler is frame synchronous, polynomial 1 + x^6 + x^7, length 127.
// [R05] Scrambler loads all ones at row 1 column 37; earlier first-row bytes stay clear.
// [R06] Each scrambled bit XORs the seventh stage; scrambler runs to frame end.
// [R07] Reserved first-row bytes are unscrambled, so they carry a run-free pattern.
// [R08] Receive descrambles with the same sequence, reset point and polynomial.
// [R09] Receive checks parity of previous scrambled frame and flags errored blocks.
// [R10] Receive extracts the trace byte and presents the accepted value.
// [R11] Receive flags mismatch between accepted trace and expected trace.
// [R12] Server fail or mismatch drives both all-ones insertion and trail fail.
// [R13] Receive output turns all ones, and back, within 250 microseconds.
// [R14] All ones are regenerated after descrambling while server fail is active.
// [R15] Payload multiplexer maps 9612 payload bytes per frame into fixed positions.
// [R16] Payload server fail forces transmitted payload to all ones within 250 microseconds.
// [R17] An unconnected payload server-fail input counts as inactive.
// [R18] Demultiplexer separates payload; its server fail follows the trail-fail signal.
// [R19] Channel, orderwire and user bytes are undefined without a source.
// [R20] Frame is 9 rows of 1080 bytes, 36 overhead columns, MSB first.
// [R21] Errored blocks and defect seconds are counted per one-second strobe.
`timescale 1ns/1ps
module stm4_regen_section_termination #(
    parameter int AIS_LIMIT_CYCLES = stm4_rs_pkg::AIS_LIMIT_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tx_frame_start,
    input wire logic [7:0] payload_in_data,
    input wire logic payload_in_valid,
    output logic payload_in_ready,
    input wire logic payload_server_fail = 1'b0, // [R17]
    input wire logic [7:0] tx_trace_identifier,
    output logic [7:0] tx_line_data,
    input wire logic rx_frame_start,
    input wire logic [7:0] rx_line_data,
    input wire logic incoming_server_fail,
    input wire logic [7:0] expected_trace_identifier,
    input wire logic mismatch_detect_disable,
    input wire logic termination_point_monitor_mode,
    input wire logic one_second,
    output logic [7:0] payload_out_data,
    output logic payload_out_valid,
    output logic [7:0] accepted_trace_identifier,
    output logic trace_mismatch_defect,
    output logic trace_mismatch_report,
    output logic all_ones_insert_action,
    output logic trail_fail_action,
    output logic server_fail_action,
    output logic near_errored_block,
    output logic [15:0] near_errored_block_count,
    output logic near_defect_second
);
    function automatic stm4_rs_pkg::pos_type pos_advance(input stm4_rs_pkg::pos_type p);
        stm4_rs_pkg::pos_type n;
        n = p;
        if (p.col == stm4_rs_pkg::LAST_COL) begin
            n.col = '0;
            n.row = (p.row == stm4_rs_pkg::LAST_ROW) ? 4'h0 : p.row + 4'h1;
        end else begin
            n.col = p.col + 11'h001;
        end
        return n;
    endfunction : pos_advance

    // Payload is every byte outside rows 1-3 columns 1-36: 9720 - 108 = 9612 bytes.
    function automatic stm4_rs_pkg::byte_kind_type classify(input stm4_rs_pkg::pos_type p);
        if (p.row == 4'h0 && p.col < stm4_rs_pkg::A1_END_COL) begin
            return stm4_rs_pkg::OH_A1;
        end else if (p.row == 4'h0 && p.col < stm4_rs_pkg::A2_END_COL) begin
            return stm4_rs_pkg::OH_A2;
        end else if (p.row == 4'h0 && p.col == stm4_rs_pkg::TRACE_COL) begin
            return stm4_rs_pkg::OH_TRACE;
        end else if (p.row == 4'h0 && p.col < stm4_rs_pkg::SOH_COLS) begin
            return stm4_rs_pkg::OH_SPARE_CLEAR;
        end else if (p.row == stm4_rs_pkg::PARITY_ROW && p.col == stm4_rs_pkg::PARITY_COL) begin
            return stm4_rs_pkg::OH_PARITY;
        end else if (p.row < stm4_rs_pkg::OH_ROWS && p.col < stm4_rs_pkg::SOH_COLS) begin
            return stm4_rs_pkg::OH_SPARE_SCR;
        end
        return stm4_rs_pkg::OH_PAYLOAD; // [R15] [R20]
    endfunction : classify

    // Returns {next state, keystream byte}; keystream MSB is the first bit on the line.
    function automatic logic [14:0] scramble_step(input logic [6:0] s_in);
        logic [6:0] s;
        logic [7:0] ks;
        s = s_in;
        ks = '0;
        for (int i = 7; i >= 0; i--) begin
            ks[i] = s[6];
            s = {s[5:0], s[6] ^ s[5]};
        end
        return {s, ks};
    endfunction : scramble_step

    function automatic logic is_scrambled(input stm4_rs_pkg::pos_type p);
        return !(p.row == 4'h0 && p.col < stm4_rs_pkg::SOH_COLS);
    endfunction : is_scrambled

    function automatic logic is_seed_point(input stm4_rs_pkg::pos_type p);
        return p.row == 4'h0 && p.col == stm4_rs_pkg::SOH_COLS;
    endfunction : is_seed_point

    // Transmit path.
    stm4_rs_pkg::pos_type tx_pos_r, tx_pos_nxt, tx_pos;
    stm4_rs_pkg::byte_kind_type tx_kind;
    logic [6:0] tx_scr_r, tx_scr_nxt, tx_scr_cur;
    logic [7:0] tx_ks, tx_raw, tx_line_nxt;
    logic [7:0] tx_line_r, tx_acc_r, tx_acc_nxt, tx_bip_r, tx_bip_nxt;
    logic [7:0] fifo_data;
    logic fifo_valid, fifo_take;

    stm4_payload_fifo #(.WIDTH(8), .DEPTH(8)) payload_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_data(payload_in_data),
        .in_valid(payload_in_valid),
        .in_ready(payload_in_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_take)
    );

    always_comb begin
        tx_pos = tx_frame_start ? '0 : tx_pos_r;
        tx_pos_nxt = pos_advance(tx_pos);
        tx_kind = classify(tx_pos);
        tx_scr_cur = is_seed_point(tx_pos) ? stm4_rs_pkg::SCR_SEED : tx_scr_r; // [R05]
        {tx_scr_nxt, tx_ks} = scramble_step(tx_scr_cur); // [R04]
        if (!is_scrambled(tx_pos)) begin
            tx_scr_nxt = tx_scr_r;
        end
        // The FIFO drains only at payload positions; an underrun sends all ones.
        fifo_take = (tx_kind == stm4_rs_pkg::OH_PAYLOAD);
        case (tx_kind)
            stm4_rs_pkg::OH_A1: tx_raw = stm4_rs_pkg::A1_BYTE; // [R01]
            stm4_rs_pkg::OH_A2: tx_raw = stm4_rs_pkg::A2_BYTE; // [R01]
            stm4_rs_pkg::OH_TRACE: tx_raw = tx_trace_identifier; // [R02]
            stm4_rs_pkg::OH_PARITY: tx_raw = tx_bip_r; // [R03]
            stm4_rs_pkg::OH_PAYLOAD: begin
                tx_raw = (payload_server_fail || !fifo_valid) ? stm4_rs_pkg::ONES_BYTE : fifo_data; // [R16]
            end
            default: tx_raw = stm4_rs_pkg::FILL_BYTE; // [R07] [R19]
        endcase
        tx_line_nxt = is_scrambled(tx_pos) ? tx_raw ^ tx_ks : tx_raw; // [R06]
        tx_acc_nxt = (tx_pos == '0) ? tx_line_nxt : tx_acc_r ^ tx_line_nxt; // [R03]
        tx_bip_nxt = (tx_pos == '0) ? tx_acc_r : tx_bip_r;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_pos_r <= '0;
            tx_scr_r <= stm4_rs_pkg::SCR_SEED;
            tx_line_r <= '0;
            tx_acc_r <= '0;
            tx_bip_r <= '0;
        end else begin
            tx_pos_r <= tx_pos_nxt;
            tx_scr_r <= tx_scr_nxt;
            tx_line_r <= tx_line_nxt;
            tx_acc_r <= tx_acc_nxt;
            tx_bip_r <= tx_bip_nxt;
        end
    end

    assign tx_line_data = tx_line_r;

    // Receive path.
    stm4_rs_pkg::pos_type rx_pos_r, rx_pos_nxt, rx_pos;
    stm4_rs_pkg::byte_kind_type rx_kind;
    logic [6:0] rx_scr_r, rx_scr_nxt, rx_scr_cur;
    logic [7:0] rx_ks, rx_descr;
    logic [7:0] rx_acc_r, rx_acc_nxt, rx_bip_r, rx_bip_nxt;
    logic rx_bip_ok_r, rx_bip_ok_nxt;
    logic [7:0] trace_cand_r, trace_cand_nxt, acc_trace_r, acc_trace_nxt;
    logic [1:0] trace_same_r, trace_same_nxt;
    logic defect_r, defect_nxt, report_r, report_nxt, ais_r, ais_nxt;
    logic [7:0] out_data_r, out_data_nxt;
    logic out_valid_r, out_valid_nxt, errored_r, errored_nxt;
    logic [15:0] ebc_acc_r, ebc_acc_nxt, ebc_r, ebc_nxt;
    logic ds_acc_r, ds_acc_nxt, ds_r, ds_nxt;

    always_comb begin
        rx_pos = rx_frame_start ? '0 : rx_pos_r;
        rx_pos_nxt = pos_advance(rx_pos);
        rx_kind = classify(rx_pos);
        rx_scr_cur = is_seed_point(rx_pos) ? stm4_rs_pkg::SCR_SEED : rx_scr_r; // [R08]
        {rx_scr_nxt, rx_ks} = scramble_step(rx_scr_cur);
        if (!is_scrambled(rx_pos)) begin
            rx_scr_nxt = rx_scr_r;
        end
        rx_descr = is_scrambled(rx_pos) ? rx_line_data ^ rx_ks : rx_line_data; // [R08]
        rx_acc_nxt = (rx_pos == '0) ? rx_line_data : rx_acc_r ^ rx_line_data;
        rx_bip_nxt = (rx_pos == '0) ? rx_acc_r : rx_bip_r;
        // No parity verdict until the first receive frame start has been seen.
        rx_bip_ok_nxt = rx_bip_ok_r || (rx_pos == '0 && rx_frame_start);
        errored_nxt = (rx_kind == stm4_rs_pkg::OH_PARITY) && rx_bip_ok_r && (rx_descr != rx_bip_r); // [R09]
        trace_cand_nxt = trace_cand_r;
        trace_same_nxt = trace_same_r;
        acc_trace_nxt = acc_trace_r;
        if (rx_kind == stm4_rs_pkg::OH_TRACE) begin
            if (rx_descr == trace_cand_r) begin
                if (trace_same_r == stm4_rs_pkg::TRACE_REPEAT) begin
                    acc_trace_nxt = trace_cand_r; // [R10]
                end else begin
                    trace_same_nxt = trace_same_r + 2'h1;
                end
            end else begin
                trace_cand_nxt = rx_descr;
                trace_same_nxt = '0;
            end
        end
        defect_nxt = !mismatch_detect_disable && (acc_trace_r != expected_trace_identifier); // [R11]
        report_nxt = termination_point_monitor_mode && defect_r;
        ais_nxt = incoming_server_fail || defect_r; // [R12]
        out_valid_nxt = (rx_kind == stm4_rs_pkg::OH_PAYLOAD); // [R18]
        // Ones are forced after the descrambler, since an upstream all-ones pattern is lost there.
        out_data_nxt = ais_nxt ? stm4_rs_pkg::ONES_BYTE : rx_descr; // [R13] [R14]
        ebc_acc_nxt = (errored_r && ebc_acc_r != stm4_rs_pkg::COUNT_MAX) ? ebc_acc_r + 16'h0001 : ebc_acc_r;
        ds_acc_nxt = ds_acc_r || ais_r;
        ebc_nxt = ebc_r;
        ds_nxt = ds_r;
        if (one_second) begin
            ebc_nxt = ebc_acc_nxt; // [R21]
            ds_nxt = ds_acc_nxt; // [R21]
            ebc_acc_nxt = '0;
            ds_acc_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_pos_r <= '0;
            rx_scr_r <= stm4_rs_pkg::SCR_SEED;
            rx_acc_r <= '0;
            rx_bip_r <= '0;
            rx_bip_ok_r <= 1'b0;
            trace_cand_r <= '0;
            trace_same_r <= '0;
            acc_trace_r <= '0;
            defect_r <= 1'b0;
            report_r <= 1'b0;
            ais_r <= 1'b0;
            out_data_r <= '0;
            out_valid_r <= 1'b0;
            errored_r <= 1'b0;
            ebc_acc_r <= '0;
            ebc_r <= '0;
            ds_acc_r <= 1'b0;
            ds_r <= 1'b0;
        end else begin
            rx_pos_r <= rx_pos_nxt;
            rx_scr_r <= rx_scr_nxt;
            rx_acc_r <= rx_acc_nxt;
            rx_bip_r <= rx_bip_nxt;
            rx_bip_ok_r <= rx_bip_ok_nxt;
            trace_cand_r <= trace_cand_nxt;
            trace_same_r <= trace_same_nxt;
            acc_trace_r <= acc_trace_nxt;
            defect_r <= defect_nxt;
            report_r <= report_nxt;
            ais_r <= ais_nxt;
            out_data_r <= out_data_nxt;
            out_valid_r <= out_valid_nxt;
            errored_r <= errored_nxt;
            ebc_acc_r <= ebc_acc_nxt;
            ebc_r <= ebc_nxt;
            ds_acc_r <= ds_acc_nxt;
            ds_r <= ds_nxt;
        end
    end

    assign payload_out_data = out_data_r;
    assign payload_out_valid = out_valid_r;
    assign accepted_trace_identifier = acc_trace_r;
    assign trace_mismatch_defect = defect_r;
    assign trace_mismatch_report = report_r;
    assign all_ones_insert_action = ais_r;
    assign trail_fail_action = ais_r; // [R12]
    assign server_fail_action = ais_r; // [R18]
    assign near_errored_block = errored_r;
    assign near_errored_block_count = ebc_r;
    assign near_defect_second = ds_r;

    // Cycles with insertion declared but no all-ones payload byte seen yet.
    logic [31:0] ais_wait_r;
    always_ff @(posedge clk) begin
        if (sys_rst || !ais_r || (out_valid_r && out_data_r == stm4_rs_pkg::ONES_BYTE)) begin
            ais_wait_r <= '0;
        end else begin
            ais_wait_r <= ais_wait_r + 32'h1;
        end
    end

    tx_align_a: assert property (@(posedge clk) disable iff (sys_rst) // [R01]
        tx_kind == stm4_rs_pkg::OH_A1 |=> tx_line_data == stm4_rs_pkg::A1_BYTE)
        else $error("first alignment byte wrong");
    tx_trace_a: assert property (@(posedge clk) disable iff (sys_rst) // [R02]
        tx_kind == stm4_rs_pkg::OH_TRACE |=> tx_line_data == $past(tx_trace_identifier))
        else $error("transmitted trace byte wrong");
    tx_parity_a: assert property (@(posedge clk) disable iff (sys_rst) // [R03]
        tx_kind == stm4_rs_pkg::OH_PARITY |=> (tx_line_data ^ $past(tx_ks)) == $past(tx_bip_r))
        else $error("parity byte does not carry previous frame parity");
    scr_seed_a: assert property (@(posedge clk) disable iff (sys_rst) // [R05]
        is_seed_point(tx_pos) |=> tx_line_data == ($past(tx_raw) ^ stm4_rs_pkg::SCR_FIRST_KEY))
        else $error("scrambler not loaded with all ones");
    tx_ais_a: assert property (@(posedge clk) disable iff (sys_rst) // [R16]
        payload_server_fail && tx_kind == stm4_rs_pkg::OH_PAYLOAD
        |=> tx_line_data == ($past(tx_ks) ^ stm4_rs_pkg::ONES_BYTE))
        else $error("payload not all ones under server fail");
    rx_fail_a: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
        incoming_server_fail |=> all_ones_insert_action && trail_fail_action && server_fail_action)
        else $error("server fail did not raise insertion and trail fail");
    rx_ones_a: assert property (@(posedge clk) disable iff (sys_rst) // [R14]
        all_ones_insert_action && payload_out_valid |-> payload_out_data == stm4_rs_pkg::ONES_BYTE)
        else $error("payload output not all ones during insertion");
    ais_time_a: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
        ais_wait_r < AIS_LIMIT_CYCLES)
        else $error("all ones not delivered in time");
    tim_detect_a: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
        (!mismatch_detect_disable && accepted_trace_identifier != expected_trace_identifier)[*2]
        |-> trace_mismatch_defect)
        else $error("trace mismatch not flagged");
    parity_flag_a: assert property (@(posedge clk) disable iff (sys_rst) // [R09]
        near_errored_block |-> $past(rx_kind) == stm4_rs_pkg::OH_PARITY)
        else $error("errored block flagged outside parity byte");

    ais_seen_c: cover property (@(posedge clk) disable iff (sys_rst) $rose(all_ones_insert_action));
    errored_c: cover property (@(posedge clk) disable iff (sys_rst) near_errored_block);
    trace_acc_c: cover property (@(posedge clk) disable iff (sys_rst) $changed(accepted_trace_identifier));
    fifo_full_c: cover property (@(posedge clk) disable iff (sys_rst) payload_in_valid && !payload_in_ready);

endmodule : stm4_regen_section_termination

//--- stm4_line_loop.sv
/* Line-side partner: loops the transmitted line bytes back as received bytes,
   with a single-bit error on request. Assumes tx bytes trail their position by one cycle. */
`timescale 1ns/1ps
module stm4_line_loop (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] tx_line_data,
    input wire logic tx_frame_start,
    input wire logic flip_bit,
    output logic [7:0] rx_line_data,
    output logic rx_frame_start
);
    // The strobe is delayed so it lines up with the registered transmit byte.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_frame_start <= 1'b0;
        end else begin
            rx_frame_start <= tx_frame_start;
        end
    end
    assign rx_line_data = tx_line_data ^ {7'h00, flip_bit};
endmodule : stm4_line_loop

//--- tb_top.sv
/* Self-checking bench: line looped back through the partner, checks framing,
   scrambling, payload, trace, insertion, parity and counts. Assumes 9720-byte frames. */
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic tx_frame_start, payload_in_ready, rx_frame_start, flip_bit = 1'b0;
    logic [7:0] payload_in_data = 8'h00;
    logic payload_in_valid = 1'b0;
    logic payload_server_fail = 1'b0;
    logic [7:0] tx_trace_identifier = 8'h5a;
    logic [7:0] expected_trace_identifier = 8'h5a;
    logic incoming_server_fail = 1'b0;
    logic mismatch_detect_disable = 1'b1;
    logic termination_point_monitor_mode = 1'b0;
    logic one_second = 1'b0;
    logic [7:0] tx_line_data, rx_line_data, payload_out_data, accepted_trace_identifier;
    logic payload_out_valid, trace_mismatch_defect, trace_mismatch_report, all_ones_insert_action;
    logic trail_fail_action, server_fail_action, near_errored_block, near_defect_second;
    logic [15:0] near_errored_block_count;
    logic [7:0] row1 [0:43];
    int pos = 0, frm = 1, cycles = 0, n_eb = 0, n_mismatch = 0, checks = 0;

    stm4_regen_section_termination #(.AIS_LIMIT_CYCLES(64)) dut_u (.clk(clk), .sys_rst(sys_rst),
        .tx_frame_start(tx_frame_start), .payload_in_data(payload_in_data),
        .payload_in_valid(payload_in_valid), .payload_in_ready(payload_in_ready),
        .payload_server_fail(payload_server_fail), .tx_trace_identifier(tx_trace_identifier),
        .tx_line_data(tx_line_data), .rx_frame_start(rx_frame_start), .rx_line_data(rx_line_data),
        .incoming_server_fail(incoming_server_fail), .expected_trace_identifier(expected_trace_identifier),
        .mismatch_detect_disable(mismatch_detect_disable),
        .termination_point_monitor_mode(termination_point_monitor_mode), .one_second(one_second),
        .payload_out_data(payload_out_data), .payload_out_valid(payload_out_valid),
        .accepted_trace_identifier(accepted_trace_identifier), .trace_mismatch_defect(trace_mismatch_defect),
        .trace_mismatch_report(trace_mismatch_report), .all_ones_insert_action(all_ones_insert_action),
        .trail_fail_action(trail_fail_action), .server_fail_action(server_fail_action),
        .near_errored_block(near_errored_block), .near_errored_block_count(near_errored_block_count),
        .near_defect_second(near_defect_second));
    stm4_line_loop loop_u (.clk(clk), .sys_rst(sys_rst), .tx_line_data(tx_line_data),
        .tx_frame_start(tx_frame_start), .flip_bit(flip_bit), .rx_line_data(rx_line_data),
        .rx_frame_start(rx_frame_start));

    initial begin
        forever #4 clk = ~clk;
    end
    assign tx_frame_start = !sys_rst && pos == 0;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (sys_rst || pos == 9719) begin
            pos <= 0;
            frm <= sys_rst ? 1 : frm + 1;
        end else begin
            pos <= pos + 1;
        end
        if (!sys_rst && frm == 1 && pos >= 1 && pos <= 44) begin
            row1[pos-1] <= tx_line_data;
        end
        if (near_errored_block === 1'b1) begin
            n_eb <= n_eb + 1;
        end
        // The test ends early in frame 6, after about 50000 cycles; the ceiling leaves margin.
        if (cycles == 70000) begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wait_pos(input int f, input int p);
        while (frm != f || pos != p) begin
            @(posedge clk);
        end
    endtask : wait_pos

    task automatic expect_out(input logic [7:0] exp);
        do @(posedge clk); while (payload_out_valid !== 1'b1);
        check(16'(payload_out_data), 16'(exp));
    endtask : expect_out

    // Nine offers into an empty FIFO during overhead: the ninth is refused, so it
    // must never reach the far end and an underrun byte of ones follows.
    task automatic round(input logic [7:0] base, input logic fail);
        payload_server_fail <= fail;
        for (int i = 0; i < 9; i++) begin
            payload_in_data <= (i == 8) ? 8'h77 : base + 8'(i);
            payload_in_valid <= 1'b1;
            @(posedge clk);
        end
        check(16'(payload_in_ready), 16'h0000);
        payload_in_valid <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            expect_out((fail || i == 8) ? 8'hff : base + 8'(i));
        end
        payload_server_fail <= 1'b0;
    endtask : round

    task automatic test_done();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    initial begin
        logic [6:0] s;
        logic [7:0] k;
        logic [7:0] exp;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        check(16'({payload_in_ready, payload_out_valid, trace_mismatch_defect}), 16'h0004);
        wait_pos(1, 60);
        s = 7'h7f;
        for (int c = 0; c < 44; c++) begin
            if (c < 36) begin
                exp = c < 12 ? 8'hf6 : c < 24 ? 8'h28 : c == 24 ? 8'h5a : 8'haa;
            end else begin
                for (int b = 0; b < 8; b++) begin
                    k = {k[6:0], s[6]};
                    s = {s[5:0], s[6] ^ s[5]};
                end
                exp = 8'hff ^ k;
            end
            check(16'(row1[c]), 16'(exp));
        end
        wait_pos(2, 0);
        round(8'h10, 1'b0);
        wait_pos(3, 0);
        round(8'h20, 1'b1);
        wait_pos(5, 1900);
        payload_in_data <= 8'h00;
        payload_in_valid <= 1'b1;
        wait_pos(5, 2000);
        check(16'(accepted_trace_identifier), 16'h005a);
        check(16'(n_eb), 16'h0000);
        expect_out(8'h00);
        expected_trace_identifier <= 8'h33;
        repeat (4) @(posedge clk);
        check(16'(trace_mismatch_defect), 16'h0000);
        mismatch_detect_disable <= 1'b0;
        termination_point_monitor_mode <= 1'b1;
        repeat (4) @(posedge clk);
        check(16'({trace_mismatch_defect, trace_mismatch_report, all_ones_insert_action,
            trail_fail_action, server_fail_action}), 16'h001f);
        expect_out(8'hff);
        expected_trace_identifier <= 8'h5a;
        repeat (4) @(posedge clk);
        check(16'({trace_mismatch_defect, all_ones_insert_action}), 16'h0000);
        expect_out(8'h00);
        incoming_server_fail <= 1'b1;
        repeat (3) @(posedge clk);
        check(16'({all_ones_insert_action, trail_fail_action, server_fail_action}), 16'h0007);
        expect_out(8'hff);
        incoming_server_fail <= 1'b0;
        flip_bit <= 1'b1;
        @(posedge clk);
        flip_bit <= 1'b0;
        wait_pos(6, 1200);
        check(16'(n_eb), 16'h0001);
        one_second <= 1'b1;
        @(posedge clk);
        one_second <= 1'b0;
        repeat (2) @(posedge clk);
        check(near_errored_block_count, 16'h0001);
        check(16'(near_defect_second), 16'h0001);
        test_done();
    end
endmodule : tb_top
